// >>> common/i2c_regs_pkg.sv
// Shared constants for the two-wire register access port
package i2c_regs_pkg;
  // Seven-bit base addresses picked by the select pin
  localparam logic [6:0] BASE_ADDR_LOW  = 7'h44;
  localparam logic [6:0] BASE_ADDR_HIGH = 7'h45;
  // Register map
  localparam int         REG_COUNT            = 32;
  localparam logic [7:0] BRIGHTNESS_CONTROL   = 8'h0a;
  localparam logic [7:0] REG_RESET_VALUE      = 8'h00;
  localparam logic [7:0] POINTER_RESET_VALUE  = 8'h00;
  // Bit counting
  localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
  localparam logic [2:0] BIT_COUNT_INIT = 3'h0;
  // Link timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int MAX_BIT_RATE_KBPS = 100;
  localparam int LINK_BIT_NS      = 1000000 / MAX_BIT_RATE_KBPS;
  localparam int LINK_BIT_CYCLES  = LINK_BIT_NS / CLK_PERIOD_NS;
endpackage

// >>> common/link_events_if.sv
// Decoded line events between the line watcher and the slave core
`timescale 1ns/1ns
interface link_events_if;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sdaLevel;
  modport watcher (output sclRise, output sclFall, output startSeen,
                   output stopSeen, output sdaLevel);
  modport core (input sclRise, input sclFall, input startSeen,
                input stopSeen, input sdaLevel);
endinterface

// >>> verilog/line_watcher.sv
// Synchronises the two bus lines and decodes clock edges, start and stop
`timescale 1ns/1ns
module line_watcher (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   sclIn,
  input  wire logic   sdaIn,
  link_events_if.watcher ev
);
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic       sclLast;
  logic       sdaLast;
  logic [1:0] next_sclSync;
  logic [1:0] next_sdaSync;

  always_comb begin
    next_sclSync = {sclSync[0], sclIn};
    next_sdaSync = {sdaSync[0], sdaIn};
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else begin
      sclSync <= next_sclSync;
      sdaSync <= next_sdaSync;
      sclLast <= sclSync[1];
      sdaLast <= sdaSync[1];
    end
  end

  always_comb begin
    ev.sclRise   = sclSync[1] & ~sclLast;
    ev.sclFall   = ~sclSync[1] & sclLast;
    ev.startSeen = sclSync[1] & sclLast & sdaLast & ~sdaSync[1];
    ev.stopSeen  = sclSync[1] & sclLast & ~sdaLast & sdaSync[1];
    ev.sdaLevel  = sdaSync[1];
  end
endmodule

// >>> verilog/i2c_slave_register_access.sv
// Two-wire slave port giving a master access to the 8-bit control registers
`timescale 1ns/1ns
module i2c_slave_register_access (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       slave_addr_select_pin,
  output logic [7:0]      brightnessControl,
  output logic [7:0]      regPointer,
  output logic            busy
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [6:0] {
    IDLE     = 7'b0000001,
    ADDR     = 7'b0000010,
    ADDR_ACK = 7'b0000100,
    WRITE    = 7'b0001000,
    WR_ACK   = 7'b0010000,
    READ     = 7'b0100000,
    RD_ACK   = 7'b1000000
  } state_t;

  state_t     state;
  state_t     next_state;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic [2:0] bitCount;
  logic [2:0] next_bitCount;
  logic       ptrLoaded;
  logic       next_ptrLoaded;
  logic       readMode;
  logic       next_readMode;
  logic [7:0] pointer;
  logic [7:0] next_pointer;
  logic       drive;
  logic       next_drive;
  logic       byteFull;
  logic       next_byteFull;
  logic [7:0] ptrData;
  logic       wrEn;
  logic [7:0] wrData;
  logic [7:0] regs [i2c_regs_pkg::REG_COUNT];
  logic [7:0] ownAddrMsbs;
  logic       selSync0;
  logic       selSync1;

  link_events_if ev ();

  line_watcher watcher (
    .clk   (clk),
    .rst_n (rst_n),
    .sclIn (sclIn),
    .sdaIn (sdaIn),
    .ev    (ev)
  );

  // Select pin is outside the clock domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      selSync0 <= 1'b0;
      selSync1 <= 1'b0;
    end else begin
      selSync0 <= slave_addr_select_pin;
      selSync1 <= selSync0;
    end
  end

  always_comb begin
    ownAddrMsbs = {(selSync1 ? i2c_regs_pkg::BASE_ADDR_HIGH
                             : i2c_regs_pkg::BASE_ADDR_LOW), 1'b0};
  end

  // Out-of-range pointer reads back zero
  function automatic logic [7:0] readReg(input logic [7:0] idx);
    readReg = (idx < 8'(i2c_regs_pkg::REG_COUNT)) ? regs[idx[4:0]] : 8'h00;
  endfunction

  always_comb begin
    ptrData = readReg(pointer);
  end

  // ****************************************
  // Protocol engine
  // ****************************************
  // Slave only: the clock line is never driven
  always_comb begin
    next_state     = state;
    next_shiftReg  = shiftReg;
    next_bitCount  = bitCount;
    next_ptrLoaded = ptrLoaded;
    next_readMode  = readMode;
    next_pointer   = pointer;
    next_drive     = drive;
    next_byteFull  = byteFull;
    wrEn           = 1'b0;
    wrData         = shiftReg;
    if (ev.stopSeen) begin
      next_state = IDLE;
      next_drive = 1'b0;
    end else if (ev.startSeen) begin
      // Start or repeated start; pointer untouched
      next_state     = ADDR;
      next_bitCount  = i2c_regs_pkg::BIT_COUNT_INIT;
      next_ptrLoaded = 1'b0;
      next_byteFull  = 1'b0;
      next_drive     = 1'b0;
    end else begin
      case (state)
        IDLE: begin
          next_drive = 1'b0;
        end
        ADDR, WRITE: begin
          if (ev.sclRise) begin
            next_shiftReg = {shiftReg[6:0], ev.sdaLevel};
            next_bitCount = bitCount + 3'h1;
            next_byteFull = (bitCount == i2c_regs_pkg::BIT_COUNT_LAST);
          end
          // Bits count on rises: the fall after a start carries no bit
          if (ev.sclFall) begin
            if (byteFull) begin
              next_byteFull = 1'b0;
              if (state == ADDR) begin
                if (shiftReg[7:1] == ownAddrMsbs[7:1]) begin
                  next_state    = ADDR_ACK;
                  next_readMode = shiftReg[0];
                  next_drive    = 1'b1;
                end else begin
                  next_state = IDLE;
                end
              end else begin
                next_state = WR_ACK;
                next_drive = 1'b1;
                if (!ptrLoaded) begin
                  next_pointer   = shiftReg;
                  next_ptrLoaded = 1'b1;
                end else begin
                  wrEn         = 1'b1;
                  next_pointer = pointer + 8'h01;
                end
              end
            end
          end
        end
        ADDR_ACK, WR_ACK: begin
          if (ev.sclFall) begin
            next_bitCount = i2c_regs_pkg::BIT_COUNT_INIT;
            if (readMode && state == ADDR_ACK) begin
              // Load from current pointer and drive MSB
              next_shiftReg = ptrData;
              next_pointer  = pointer + 8'h01;
              next_drive    = ~ptrData[7];
              next_state    = READ;
            end else begin
              next_drive = 1'b0;
              next_state = WRITE;
            end
          end
        end
        READ: begin
          if (ev.sclFall) begin
            next_bitCount = bitCount + 3'h1;
            if (bitCount == i2c_regs_pkg::BIT_COUNT_LAST) begin
              next_drive = 1'b0;
              next_state = RD_ACK;
            end else begin
              next_shiftReg = {shiftReg[6:0], 1'b0};
              next_drive    = ~shiftReg[6];
            end
          end
        end
        RD_ACK: begin
          if (ev.sclRise) begin
            if (ev.sdaLevel) begin
              next_state = IDLE;
            end else begin
              next_readMode = 1'b1;
            end
          end
          if (ev.sclFall) begin
            next_bitCount = i2c_regs_pkg::BIT_COUNT_INIT;
            next_shiftReg = ptrData;
            next_pointer  = pointer + 8'h01;
            next_drive    = ~ptrData[7];
            next_state    = READ;
          end
        end
        default: begin
          next_state = IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= IDLE;
      shiftReg  <= 8'h00;
      bitCount  <= i2c_regs_pkg::BIT_COUNT_INIT;
      ptrLoaded <= 1'b0;
      readMode  <= 1'b0;
      pointer   <= i2c_regs_pkg::POINTER_RESET_VALUE;
      drive     <= 1'b0;
      byteFull  <= 1'b0;
    end else begin
      state     <= next_state;
      shiftReg  <= next_shiftReg;
      bitCount  <= next_bitCount;
      ptrLoaded <= next_ptrLoaded;
      readMode  <= next_readMode;
      pointer   <= next_pointer;
      drive     <= next_drive;
      byteFull  <= next_byteFull;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  // Writes beyond the array are dropped
  genvar gi;
  generate
    for (gi = 0; gi < i2c_regs_pkg::REG_COUNT; gi++) begin : gReg
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          regs[gi] <= i2c_regs_pkg::REG_RESET_VALUE;
        end else if (wrEn && pointer == 8'(gi)) begin
          regs[gi] <= wrData;
        end
      end
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdaOut            <= 1'b0;
      sdaOe             <= 1'b0;
      brightnessControl <= i2c_regs_pkg::REG_RESET_VALUE;
      regPointer        <= i2c_regs_pkg::POINTER_RESET_VALUE;
      busy              <= 1'b0;
    end else begin
      sdaOut            <= 1'b0;
      sdaOe             <= next_drive;
      brightnessControl <= regs[i2c_regs_pkg::BRIGHTNESS_CONTROL[4:0]];
      regPointer        <= next_pointer;
      busy              <= (next_state != IDLE);
    end
  end
endmodule

// >>> verification/i2c_port_assertions.sv
// Concurrent checks on the two-wire register port
`timescale 1ns/1ns
module i2c_port_assertions (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       slave_addr_select_pin,
  input wire logic [7:0] brightnessControl,
  input wire logic [7:0] regPointer,
  input wire logic       busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ***
  // Line conditions
  // ***
  sequence startSeq;
    sclIn && $past(sclIn) && $fell(sdaIn);
  endsequence
  sequence stopSeq;
    sclIn && $past(sclIn) && $rose(sdaIn);
  endsequence
  a_drive_low:
    assert property (sdaOe |-> !sdaOut) else $error("sda driven high");
  a_ack_hold:
    assert property ($rose(sdaOe) |=> sdaOe [*2])
    else $error("ack not held");
  // Data may only move while the clock is low
  a_oe_scl_low:
    assert property ($changed(sdaOe) |-> !sclIn)
    else $error("sda moved with clock high");
  a_start_busy:
    assert property (startSeq |-> ##[1:6] busy)
    else $error("start not seen");
  a_stop_idle:
    assert property (stopSeq |-> ##[1:6] !busy)
    else $error("stop not seen");
  a_idle_quiet:
    assert property (!busy |-> !sdaOe) else $error("drive while idle");
  a_ptr_kept:
    assert property (!busy && !$past(busy) |-> $stable(regPointer))
    else $error("pointer moved while idle");
  a_reg_busy:
    assert property ($changed(brightnessControl) |-> busy || $past(busy))
    else $error("register moved while idle");
endmodule
bind i2c_slave_register_access i2c_port_assertions chk_u (
  .clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe),
  .slave_addr_select_pin(slave_addr_select_pin),
  .brightnessControl(brightnessControl), .regPointer(regPointer),
  .busy(busy));

// >>> verification/link_master.sv
// Bus master model driving the two-wire link
`timescale 1ns/1ns
module link_master (
  input  wire logic clk,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaPull
);
  // ***
  // Bus cycles
  // ***
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Start and repeated start share one sequence
  task automatic start();
    tick(1);
    sdaPull = 1'b0;
    tick(3);
    sclOut = 1'b1;
    tick(4);
    sdaPull = 1'b1;
    tick(4);
    sclOut = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sdaPull = 1'b1;
    tick(3);
    sclOut = 1'b1;
    tick(4);
    sdaPull = 1'b0;
    tick(6);
  endtask
  // 800 ns bit, long low phase for the slave's answer
  task automatic bitx(input logic d, output logic q);
    tick(1);
    sdaPull = !d;
    tick(5);
    q = sdaLine;
    sclOut = 1'b1;
    tick(2);
    sclOut = 1'b0;
  endtask
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], q);
    end
    bitx(1'b1, q);
    ack = !q;
  endtask
  task automatic rdByte(input logic nack, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, b[i]);
    end
    bitx(nack, q);
  endtask
endmodule

// >>> verification/i2c_slave_register_access_test.sv
// Self-checking bench for the two-wire register port
`timescale 1ns/1ns
module i2c_slave_register_access_test;
  logic       clk;
  logic       rst_n;
  logic       sel;
  logic       scl;
  logic       pull;
  logic       sdaOut;
  logic       sdaOe;
  logic [7:0] bright;
  logic [7:0] ptr;
  logic       busy;
  logic       ack;
  logic [7:0] rd;
  int         miscompares;
  int         n_tests;
  // Pulled-up open-drain data line
  wire logic  sda = !(pull || (sdaOe && !sdaOut));
  i2c_slave_register_access dut_u (
    .clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .slave_addr_select_pin(sel),
    .brightnessControl(bright), .regPointer(ptr), .busy(busy));
  link_master mst_u (
    .clk(clk), .sdaLine(sda), .sclOut(scl), .sdaPull(pull));
  // ***
  // Checks
  // ***
  initial clk = 1'b0;
  always #50 clk = ~clk;
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(logic [7:0] b, logic e);
    mst_u.wrByte(b, ack);
    chk("ack", {7'h00, e}, {7'h00, ack});
  endtask
  task automatic recv(logic nack, logic [7:0] e);
    mst_u.rdByte(nack, rd);
    chk("rdata", e, rd);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    sel = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    mst_u.tick(3);
    chk("ptr", 8'h00, ptr);
    mst_u.start();
    send(8'h88, 1'b1);
    send(8'h0a, 1'b1);
    send(8'h55, 1'b1);
    send(8'ha3, 1'b1);
    mst_u.stop();
    chk("bright", 8'h55, bright);
    chk("ptr", 8'h0c, ptr);
    // Other base address is ignored
    mst_u.start();
    send(8'h8a, 1'b0);
    send(8'h00, 1'b0);
    mst_u.stop();
    chk("ptr", 8'h0c, ptr);
    sel = 1'b1;
    mst_u.start();
    send(8'h8a, 1'b1);
    send(8'h0a, 1'b1);
    mst_u.start();
    send(8'h8b, 1'b1);
    recv(1'b0, 8'h55);
    recv(1'b1, 8'ha3);
    // Give a wrongly continued read time to drive its next bit
    mst_u.tick(4);
    chk("oe", 8'h00, {7'h00, sdaOe});
    mst_u.stop();
    chk("ptr", 8'h0c, ptr);
    chk("busy", 8'h00, {7'h00, busy});
    // Pointer survives a stop
    mst_u.start();
    send(8'h8a, 1'b1);
    send(8'h0a, 1'b1);
    mst_u.stop();
    mst_u.start();
    send(8'h8b, 1'b1);
    recv(1'b1, 8'h55);
    mst_u.stop();
    chk("ptr", 8'h0b, ptr);
    summarize();
  end
endmodule
